//--- logic/sfsp_pkg.sv
// Shared constants and types of the synchronous FIFO slave port.
// Assumes a system clock domain and a link clock domain at the pins.
`default_nettype none
package sfsp_pkg;
  // Selectable bus clock rates in MHz
  localparam int LINK_FREQ_66_MHZ = 66;
  localparam int LINK_FREQ_100_MHZ = 100;
  // Command phase coding
  localparam logic [3:0] CMD_WRITE = 4'h1;
  localparam logic [7:0] CH_FIRST = 8'h01;
  localparam logic [7:0] CH_LAST = 8'h04;
  // Idle status byte: upper nibble unused, held high
  localparam logic [3:0] STATUS_UPPER = 4'hf;
  localparam int NUM_CH = 4;
  // Core reset outlasts its cause by this many system cycles, so that a
  // short reset pulse is still seen by the slower link clock
  localparam int RST_HOLD_W = 4;
  localparam logic [RST_HOLD_W-1:0] RST_HOLD = 4'h8;
  // Link side states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_TURN = 4'b0010,
    ST_DATA = 4'b0100,
    ST_END = 4'b1000
  } sfsp_state_t;
  // One received word with its channel and lane enables
  typedef struct packed {
    logic [1:0] channel;
    logic [3:0] lanes;
    logic [31:0] data;
  } sfsp_word_t;
  localparam int WORD_W = $bits(sfsp_word_t);
endpackage
`default_nettype wire

//--- logic/sfsp_word_cdc.sv
// Word crossing by toggle handshake from the link domain to the system.
// Assumes each side has its own synchronous active high reset.
`timescale 1ns/10ps
`default_nettype none
module sfsp_word_cdc #(
  parameter int WIDTH = 38
) (
  input wire logic i_src_clk,
  input wire logic i_src_rst,
  input wire logic i_src_valid,
  input wire logic [WIDTH-1:0] i_src_data,
  output logic o_src_ready,
  input wire logic i_dst_clk,
  input wire logic i_dst_rst,
  output logic o_dst_valid,
  output logic [WIDTH-1:0] o_dst_data
);
  logic req_r, req_nxt, ack_m_r, ack_s_r;
  logic [WIDTH-1:0] hold_r, hold_nxt;
  logic req_m_r, req_s_r, req_d_r;
  logic valid_r, valid_nxt;
  logic [WIDTH-1:0] data_r, data_nxt;

  if (WIDTH < 1) begin : g_chk
    $error("sfsp_word_cdc: WIDTH must be at least 1");
  end

  // Source ready while the last word has been acknowledged
  assign o_src_ready = (req_r == ack_s_r);

  // Source: toggle request and hold word until acknowledged
  always_comb begin
    req_nxt = req_r;
    hold_nxt = hold_r;
    if (i_src_valid && o_src_ready) begin
      req_nxt = ~req_r;
      hold_nxt = i_src_data;
    end
  end

  always_ff @(posedge i_src_clk) begin
    if (i_src_rst) begin
      req_r <= 1'b0;
      hold_r <= '0;
      ack_m_r <= 1'b0;
      ack_s_r <= 1'b0;
    end else begin
      req_r <= req_nxt;
      hold_r <= hold_nxt;
      ack_m_r <= req_d_r;
      ack_s_r <= ack_m_r;
    end
  end

  // Destination: capture held word on request edge
  always_comb begin
    valid_nxt = (req_s_r != req_d_r);
    data_nxt = valid_nxt ? hold_r : data_r;
  end

  always_ff @(posedge i_dst_clk) begin
    if (i_dst_rst) begin
      req_m_r <= 1'b0;
      req_s_r <= 1'b0;
      req_d_r <= 1'b0;
      valid_r <= 1'b0;
      data_r <= '0;
    end else begin
      req_m_r <= req_r;
      req_s_r <= req_m_r;
      req_d_r <= req_s_r;
      valid_r <= valid_nxt;
      data_r <= data_nxt;
    end
  end

  assign o_dst_valid = valid_r;
  assign o_dst_data = data_r;
endmodule
`default_nettype wire

//--- logic/sfsp_port.sv
// Slave side of a 32-bit synchronous FIFO bus, single and multi channel.
// Assumes I_LINK_CLK is the selected 66 or 100 MHz clock from a PLL, and
// that the master launches and samples on its rising edge.
// Behaviour
// (R1) Bus clock is driven out to master; 66 or 100 MHz selectable in both modes.
// (R2) Data bits 0-7 and 16-31 are inputs; bits 8-15 are bidirectional.
// (R3) Four bidirectional byte-lane enables accompany the 32-bit data bus; the port only receives them, its driver never enabled.
// (R4) Single-channel: space flag low only while receive buffer has free space.
// (R5) Single-channel: master writes only while space flag is low.
// (R6) Multi-channel: space flag pin becomes an optional status-valid output.
// (R7) Multi-channel: drive active-low receive acknowledge; unused in single mode.
// (R8) Master write strobe: write enable or transaction request by mode.
// (R9) Chip held in reset while external reset pin is low.
// (R10) External interrupt request input recognised while low.
// (R11) Multi-channel idle: device drives bits 8-15, 11-8 are channel status.
// (R12) Multi-channel: command phase on first strobe clock, data after acknowledge.
// (R13) Command phase: master signals write with lane enables equal one.
// (R14) Command phase channel byte 1 to 4 selects channel; others ignored.
// (R15) All bus signals launched and sampled on rising bus clock edge.
`timescale 1ns/10ps
`default_nettype none
module sfsp_port (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_LINK_CLK,
  input wire logic I_SEL_100,
  input wire logic I_MULTI_MODE,
  input wire logic I_CHIP_RST_N,
  input wire logic I_INT_N,
  input wire logic [sfsp_pkg::NUM_CH-1:0] I_CH_SPACE,
  output logic O_PLL_SEL_100,
  output logic O_BUS_CLK,
  input wire logic [31:0] I_DATA,
  output logic [7:0] O_DATA_HI,
  output logic O_DATA_HI_OE,
  input wire logic [3:0] I_BYTE_LANE_ENABLE,
  output logic [3:0] O_BYTE_LANE_ENABLE,
  output logic O_BYTE_LANE_ENABLE_OE,
  input wire logic I_WR_N,
  output logic O_SPACE_FLAG_LOW,
  output logic O_RECEIVE_ACK_LOW,
  output logic O_IRQ_REQ,
  output logic O_CORE_RST,
  output logic O_RX_VALID,
  output sfsp_pkg::sfsp_word_t O_RX_WORD
);
  import sfsp_pkg::*;

  // System domain state
  logic crst_m_r, crst_s_r, int_m_r, int_s_r;
  logic sel_m_r, sel_s_r, irq_r, sys_rst_r, sys_rst_nxt;
  logic [RST_HOLD_W-1:0] rst_hold_r, rst_hold_nxt;
  // Link domain state
  logic lrst_m_r, lrst_r;
  logic mode_m_r, mode_r;
  logic [NUM_CH-1:0] sp_m_r, sp_r;
  sfsp_state_t state_r, state_nxt;
  logic [1:0] ch_r, ch_nxt;
  logic ack_n_r, ack_n_nxt, space_n_r, space_n_nxt;
  logic oe_r, oe_nxt;
  logic [7:0] hi_r, hi_nxt;
  logic take, src_ready;
  sfsp_word_t word;

  // Command decode used when opening a multi-channel transaction
  function automatic logic cmd_ok(input logic [3:0] lanes,
                                  input logic [7:0] chan);
    cmd_ok = (lanes == CMD_WRITE) && (chan >= CH_FIRST) &&
             (chan <= CH_LAST);
  endfunction

  // Pin inputs into the system domain, two flops each
  always_ff @(posedge I_CLK) begin
    crst_m_r <= ~I_CHIP_RST_N;
    crst_s_r <= crst_m_r;
    int_m_r <= ~I_INT_N;
    int_s_r <= int_m_r;
    sel_m_r <= I_SEL_100;
    sel_s_r <= sel_m_r;
  end

  // Core reset from bus reset or chip reset pin, stretched by a down
  // counter so the link domain synchroniser cannot miss a short pulse
  always_comb begin
    rst_hold_nxt = rst_hold_r;
    if (I_RST || crst_s_r) begin
      rst_hold_nxt = RST_HOLD;
    end else if (rst_hold_r != '0) begin
      rst_hold_nxt = rst_hold_r - RST_HOLD_W'(1);
    end
    sys_rst_nxt = I_RST || crst_s_r || (rst_hold_r != '0); // R9
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      sys_rst_r <= 1'b1;
      rst_hold_r <= RST_HOLD;
      irq_r <= 1'b0;
      O_PLL_SEL_100 <= 1'b0;
    end else begin
      sys_rst_r <= sys_rst_nxt; // R9
      rst_hold_r <= rst_hold_nxt;
      irq_r <= int_s_r; // R10
      O_PLL_SEL_100 <= sel_s_r; // R1
    end
  end

  assign O_IRQ_REQ = irq_r;
  assign O_CORE_RST = sys_rst_r;
  // Selected clock forwarded to the master
  assign O_BUS_CLK = I_LINK_CLK; // R1

  // Reset, mode and channel space into the link domain
  always_ff @(posedge I_LINK_CLK) begin
    lrst_m_r <= sys_rst_r;
    lrst_r <= lrst_m_r;
    mode_m_r <= I_MULTI_MODE;
    mode_r <= mode_m_r;
    sp_m_r <= I_CH_SPACE;
    sp_r <= sp_m_r;
  end

  // Word taken on a rising link edge, strobe and grant both low
  always_comb begin
    word.channel = mode_r ? ch_r : 2'h0;
    word.lanes = I_BYTE_LANE_ENABLE; // R3
    word.data = I_DATA; // R2
    if (mode_r) begin
      take = state_r == ST_DATA && !I_WR_N && !ack_n_r; // R12 R15
    end else begin
      take = !I_WR_N && !space_n_r; // R5 R8 R15
    end
  end

  // Link side sequencing and registered pin outputs
  always_comb begin
    state_nxt = state_r;
    ch_nxt = ch_r;
    case (state_r)
      ST_IDLE: begin
        if (mode_r && !I_WR_N) begin // R8
          if (cmd_ok(I_BYTE_LANE_ENABLE, I_DATA[7:0])) begin // R13 R14
            ch_nxt = 2'(I_DATA[7:0] - CH_FIRST); // R14
            state_nxt = ST_TURN; // R12
          end else begin
            state_nxt = ST_END; // R14
          end
        end
      end
      ST_TURN: begin
        state_nxt = ST_DATA;
      end
      ST_DATA: begin
        if (I_WR_N) begin
          state_nxt = ST_END;
        end
      end
      ST_END: begin
        if (I_WR_N) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (!mode_r) begin
      state_nxt = ST_IDLE;
    end
    // Grant only if next edge can surely accept a word
    ack_n_nxt = !(mode_r && state_nxt == ST_DATA && src_ready && !take &&
                  sp_r[ch_nxt]); // R7 R12
    space_n_nxt = mode_r ? !(state_nxt == ST_IDLE) // R6
                         : !(sp_r[0] && src_ready && !take); // R4
    oe_nxt = mode_r && state_nxt == ST_IDLE; // R11
    hi_nxt = {STATUS_UPPER, ~sp_r}; // R11
  end

  always_ff @(posedge I_LINK_CLK) begin
    if (lrst_r) begin
      state_r <= ST_IDLE;
      ch_r <= 2'h0;
      ack_n_r <= 1'b1;
      space_n_r <= 1'b1;
      oe_r <= 1'b0;
      hi_r <= 8'hff;
    end else begin
      state_r <= state_nxt;
      ch_r <= ch_nxt;
      ack_n_r <= ack_n_nxt;
      space_n_r <= space_n_nxt;
      oe_r <= oe_nxt;
      hi_r <= hi_nxt;
    end
  end

  assign O_RECEIVE_ACK_LOW = ack_n_r; // R7
  assign O_SPACE_FLAG_LOW = space_n_r; // R4 R6
  assign O_DATA_HI = hi_r; // R2 R11
  assign O_DATA_HI_OE = oe_r; // R2
  // Lane enables are only ever received; driver kept idle
  assign O_BYTE_LANE_ENABLE = 4'hf; // R3
  assign O_BYTE_LANE_ENABLE_OE = 1'b0; // R3

  // Received words cross into the system domain
  sfsp_word_cdc #(
    .WIDTH(WORD_W)
  ) u_cdc (
    .i_src_clk(I_LINK_CLK),
    .i_src_rst(lrst_r),
    .i_src_valid(take),
    .i_src_data(word),
    .o_src_ready(src_ready),
    .i_dst_clk(I_CLK),
    .i_dst_rst(sys_rst_r),
    .o_dst_valid(O_RX_VALID),
    .o_dst_data(O_RX_WORD)
  );
endmodule
`default_nettype wire

//--- sim/sfsp_port_chk.sv
// Link side assertions of the FIFO slave port, plus the system clock irq check.
// Assumes I_RST also clears the link side logic.
`timescale 1ns/10ps
`default_nettype none
module sfsp_port_chk import sfsp_pkg::*; (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_LINK_CLK,
  input wire logic I_MULTI_MODE,
  input wire logic I_INT_N,
  input wire logic [NUM_CH-1:0] I_CH_SPACE,
  input wire logic [31:0] I_DATA,
  input wire logic [7:0] O_DATA_HI,
  input wire logic O_DATA_HI_OE,
  input wire logic [3:0] I_BYTE_LANE_ENABLE,
  input wire logic I_WR_N,
  input wire logic O_SPACE_FLAG_LOW,
  input wire logic O_RECEIVE_ACK_LOW,
  input wire logic O_IRQ_REQ
);
  default clocking cb @(posedge I_LINK_CLK); endclocking
  default disable iff (I_RST);
  // Valid write command while the bus is idle
  logic cmd_ok;
  assign cmd_ok = I_BYTE_LANE_ENABLE == CMD_WRITE && I_DATA[7:0] >= CH_FIRST
    && I_DATA[7:0] <= CH_LAST;
  sequence s_cmd; O_DATA_HI_OE && !I_WR_N && cmd_ok; endsequence
  sequence s_turn; !O_DATA_HI_OE && O_SPACE_FLAG_LOW && O_RECEIVE_ACK_LOW;
  endsequence
  // Interrupt request lives in the system clock domain
  property p_irq; @(posedge I_CLK) !I_INT_N [*4] |-> O_IRQ_REQ; endproperty
  a_irq: assert property (p_irq) else $error("irq missing");
  property p_take; !I_MULTI_MODE && !I_WR_N && !O_SPACE_FLAG_LOW |=>
    O_SPACE_FLAG_LOW; endproperty
  a_take: assert property (p_take) else $error("flag kept low");
  property p_full; (!I_MULTI_MODE && !I_CH_SPACE[0]) [*6] |->
    O_SPACE_FLAG_LOW; endproperty
  a_full: assert property (p_full) else $error("flag low when full");
  property p_single; !I_MULTI_MODE [*6] |-> O_RECEIVE_ACK_LOW &&
    !O_DATA_HI_OE; endproperty
  a_single: assert property (p_single) else $error("single drive");
  property p_status; $stable(I_CH_SPACE) [*6] ##0 O_DATA_HI_OE |->
    O_DATA_HI == {STATUS_UPPER, ~I_CH_SPACE}; endproperty
  a_status: assert property (p_status) else $error("bad status");
  property p_grant; s_cmd ##0 &I_CH_SPACE |-> !O_SPACE_FLAG_LOW ##1
    s_turn ##1 !O_RECEIVE_ACK_LOW; endproperty
  a_grant: assert property (p_grant) else $error("bad grant");
  property p_bad; O_DATA_HI_OE && !I_WR_N && !cmd_ok |=>
    O_RECEIVE_ACK_LOW [*4]; endproperty
  a_bad: assert property (p_bad) else $error("bad cmd granted");
  property p_pulse; !O_RECEIVE_ACK_LOW && !I_WR_N |=> O_RECEIVE_ACK_LOW;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
endmodule
`default_nettype wire

//--- sim/sfsp_master_model.sv
// Bus master model on the link clock.
// Assumes the bench calls its tasks; changes follow a rising edge.
`timescale 1ns/10ps
`default_nettype none
module sfsp_master_model (
  input wire logic i_clk,
  input wire logic i_space_n,
  input wire logic i_ack_n,
  output logic o_wr_n,
  output logic [31:0] o_data,
  output logic [3:0] o_be
);
  // Idle master holds strobe off and lines high
  initial begin
    o_wr_n = 1'b1;
    o_data = 32'hffff_ffff;
    o_be = 4'hf;
  end
  // One word, only after the space flag reads low
  task automatic write_word(input logic [31:0] d, input logic [3:0] be,
      output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 50 && ok !== 1'b1; n++) begin
      @(posedge i_clk);
      ok = ~i_space_n;
    end
    if (ok === 1'b1) begin
      o_wr_n <= 1'b0;
      o_data <= d;
      o_be <= be;
      @(posedge i_clk);
      o_wr_n <= 1'b1;
      o_data <= ~d; // Released lines lose the word
    end
  endtask
  // Command, then each word held until an edge finds the ack low
  task automatic burst(input logic [7:0] ch, input logic [3:0] cmd,
      input int n, input logic [31:0] base, output logic ok);
    int i;
    int t;
    i = 0;
    @(posedge i_clk);
    o_wr_n <= 1'b0;
    o_be <= cmd;
    o_data <= {24'hff_ffff, ch};
    @(posedge i_clk);
    o_be <= 4'hf;
    o_data <= base;
    for (t = 0; t < 16 && i < n; t++) begin
      @(posedge i_clk);
      if (i_ack_n === 1'b0) begin
        i++;
        t = 0;
        if (i < n) o_data <= base + i;
      end
    end
    ok = (i == n);
    o_wr_n <= 1'b1;
    o_data <= 32'hffff_ffff;
  endtask
endmodule
`default_nettype wire

//--- sim/sfsp_port_tb.sv
// Self-checking bench of the FIFO slave port.
// Assumes package, design, checker and master model compile first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  error_cnt++; $display("Error %s expected %h seen %h", n, e, g); end end
module sfsp_port_tb;
  import sfsp_pkg::*;
  logic clk, rst, lclk, sel, multi, crst_n, int_n, pll, bclk, hoe, beoe;
  logic wr_n, spc_n, ack_n, irq, core_rst, rxv;
  logic [3:0] ch_space, be_out, m_be;
  logic [7:0] hi;
  logic [31:0] m_data;
  wire logic [31:0] bus;
  sfsp_word_t rxw, rxq[$];
  int error_cnt = 0;
  int samples_checked = 0;
  // Bits 15:8 come from whichever side drives them
  assign bus = {m_data[31:16], hoe ? hi : m_data[15:8], m_data[7:0]};
  sfsp_port dut (.I_CLK(clk), .I_RST(rst), .I_LINK_CLK(lclk),
    .I_SEL_100(sel), .I_MULTI_MODE(multi), .I_CHIP_RST_N(crst_n),
    .I_INT_N(int_n), .I_CH_SPACE(ch_space), .O_PLL_SEL_100(pll),
    .O_BUS_CLK(bclk), .I_DATA(bus), .O_DATA_HI(hi), .O_DATA_HI_OE(hoe),
    .I_BYTE_LANE_ENABLE(beoe ? be_out : m_be), .O_BYTE_LANE_ENABLE(be_out),
    .O_BYTE_LANE_ENABLE_OE(beoe), .I_WR_N(wr_n), .O_SPACE_FLAG_LOW(spc_n),
    .O_RECEIVE_ACK_LOW(ack_n), .O_IRQ_REQ(irq), .O_CORE_RST(core_rst),
    .O_RX_VALID(rxv), .O_RX_WORD(rxw));
  sfsp_master_model mst (.i_clk(lclk), .i_space_n(spc_n), .i_ack_n(ack_n),
    .o_wr_n(wr_n), .o_data(m_data), .o_be(m_be));
  // Clocks and word collection
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #7;
    forever #32 lclk = ~lclk;
  end
  always @(negedge clk) if (rxv === 1'b1) rxq.push_back(rxw);
  task automatic print_verdict();
    $display("Checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic get_word(input sfsp_word_t e);
    sfsp_word_t w;
    int n = 0;
    do @(negedge clk); while (rxq.size() == 0 && ++n < 300);
    if (rxq.size() == 0) begin
      $display("Error rx_valid expected 1 seen 0");
      error_cnt++;
      print_verdict();
    end
    w = rxq.pop_front();
    `CHK("rx_word", e, w)
  endtask
  task automatic t_single();
    logic ok;
    `CHK("pll_sel66", 1'b0, pll)
    `CHK("ack_idle", 1'b1, ack_n)
    sel = 1'b1;
    idle(6);
    `CHK("pll_sel", 1'b1, pll)
    `CHK("bus_clk", lclk, bclk)
    `CHK("lane_oe", 1'b0, beoe)
    `CHK("lane_out", 4'hf, be_out)
    for (int i = 0; i < 3; i++) begin
      mst.write_word(32'h5ac3_96e0 + i, 4'hf >> i, ok);
      `CHK("wr_ok", 1'b1, ok)
      get_word('{2'h0, 4'hf >> i, 32'h5ac3_96e0 + i});
    end
    ch_space = 4'he;
    idle(20);
    `CHK("full_flag", 1'b1, spc_n)
    mst.write_word(32'h0, 4'hf, ok);
    `CHK("held_off", 1'b0, ok)
    ch_space = 4'hf;
    idle(20);
    `CHK("space_flag", 1'b0, spc_n)
    $display("single done");
  endtask
  task automatic t_multi();
    logic ok;
    logic [11:0] bad[3] = '{12'h100, 12'h105, 12'h201};
    multi = 1'b1;
    ch_space = 4'b1010;
    idle(20);
    `CHK("status", {STATUS_UPPER, 4'b0101}, hi)
    `CHK("status_valid", 1'b0, spc_n)
    ch_space = 4'hf;
    idle(20);
    for (int c = 1; c <= NUM_CH; c++) begin
      mst.burst(8'(c), CMD_WRITE, 2, 32'(c) << 24, ok);
      `CHK("burst_ok", 1'b1, ok)
      for (int w = 0; w < 2; w++)
        get_word('{2'(c - 1), 4'hf, (32'(c) << 24) + w});
    end
    for (int b = 0; b < 3; b++) begin
      mst.burst(bad[b][7:0], bad[b][11:8], 1, 32'h0, ok);
      `CHK("bad_cmd", 1'b0, ok)
    end
    idle(30);
    `CHK("no_word", 0, rxq.size())
    $display("multi done");
  endtask
  task automatic t_ctrl();
    int_n = 1'b0;
    idle(20);
    `CHK("irq", 1'b1, irq)
    int_n = 1'b1;
    crst_n = 1'b0;
    idle(20);
    `CHK("irq_off", 1'b0, irq)
    `CHK("core_rst", 1'b1, core_rst)
    `CHK("rst_oe", 1'b0, hoe)
    crst_n = 1'b1;
    idle(30);
    `CHK("core_run", 1'b0, core_rst)
    `CHK("run_oe", 1'b1, hoe)
    $display("control done");
  endtask
  initial begin
    rst = 1'b1;
    sel = 1'b0;
    multi = 1'b0;
    crst_n = 1'b1;
    int_n = 1'b1;
    ch_space = 4'hf;
    idle(2);
    rst = 1'b0;
    idle(10);
    t_single();
    t_multi();
    t_ctrl();
    print_verdict();
  end
endmodule
bind sfsp_port sfsp_port_chk chk (.*);
`default_nettype wire
